/* sim/drt_dap_model.sv */
// bus master model of the debug access port facing the register bank
`timescale 1ns/1ns
module drt_dap_model (
  // clock
  input wire logic clk,
  // write channels
  output logic [11:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  // read channels
  output logic [11:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready
);
  // ****
  // idle bus
  // ****
  // everything low at time zero, full strobes always
  initial
  begin
    awaddr = 12'h000;
    awvalid = 1'b0;
    wdata = 32'h0000_0000;
    wstrb = 4'hf;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = 12'h000;
    arvalid = 1'b0;
    rready = 1'b0;
  end
  // ****
  // transfers
  // ****
  // write: address and data offered together, each dropped once taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge clk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_done && w_done))
    begin
      @(posedge clk);
      // released payload is scrambled so a stale value cannot pass
      if (!aw_done && awready === 1'b1)
      begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
        awaddr <= ~a;
      end
      if (!w_done && wready === 1'b1)
      begin
        w_done = 1'b1;
        wvalid <= 1'b0;
        wdata <= ~d;
      end
    end
    while (bvalid !== 1'b1)
    begin
      @(posedge clk);
    end
    r = bresp;
    bready <= 1'b0;
  endtask : wr
  // read: address held until taken, data taken at the valid edge
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clk);
    end
    while (arready !== 1'b1);
    arvalid <= 1'b0;
    araddr <= ~a;
    do
    begin
      @(posedge clk);
    end
    while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rd
  // ****
  // table walk helpers
  // ****
  // component address from a table base and an entry word
  function automatic logic [31:0] comp_addr(input logic [31:0] base, input logic [31:0] e);
    return base + {e[31:12], 12'h000};
  endfunction : comp_addr
  // the walk stops at a final code or at the last slot whatever it holds
  function automatic logic is_final(input logic [31:0] e, input int idx);
    return (e[1:0] == 2'h0) || (idx == 511);
  endfunction : is_final
  // no domain given means the table's own domain
  function automatic logic [4:0] dom_of(input logic [31:0] e, input logic [4:0] own);
    return e[2] ? e[8:4] : own;
  endfunction : dom_of
endmodule : drt_dap_model

/* sim/drt_regs_tb.sv */
// self-checking bench of the debug discovery table register bank
`timescale 1ns/1ns
module drt_regs_tb;
  // ****
  // wires
  // ****
  logic clk;
  logic rst_b;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, sys_pwr_req;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  int num_errors;
  int num_checks;
  // design and far side
  drt_regs dut_u (.CLK(clk), .RST_B(rst_b), .AWADDR(awaddr), .AWPROT(3'h0),
    .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid),
    .WREADY(wready), .BRESP(bresp), .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr),
    .ARPROT(3'h0), .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata), .RRESP(rresp),
    .RVALID(rvalid), .RREADY(rready), .SYS_PWR_REQ(sys_pwr_req));
  drt_dap_model dap_u (.clk(clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
  // 25 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // ****
  // shared checks
  // ****
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // read and compare data and response
  task automatic rdc(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    dap_u.rd(a, d, r);
    chk(d, e);
    chk({30'h0, r}, {30'h0, er});
  endtask : rdc
  // write and compare response
  task automatic wrc(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    logic [1:0] r;
    dap_u.wr(a, d, r);
    chk({30'h0, r}, {30'h0, er});
  endtask : wrc
  // ****
  // scenarios
  // ****
  // identification words from the default parameters
  task automatic t_ident;
    logic [11:0] ofs [8];
    logic [31:0] val [8];
    ofs = '{12'hfe0, 12'hfe4, 12'hfe8, 12'hfec, 12'hfd0, 12'hfd4, 12'hfd8, 12'hfdc};
    val = '{32'h5a, 32'hb1, 32'h0a, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
    for (int i = 0; i < 8; i++)
      rdc(ofs[i], val[i], 2'h0);
    wrc(12'hfe8, 32'h0, 2'h0);
    rdc(12'hfe8, 32'h0a, 2'h0);
  endtask : t_ident
  // feature word, then a write that must leave it alone
  task automatic t_feature;
    rdc(12'hc00, 32'h1, 2'h0);
    wrc(12'hc00, 32'hffff_ffff, 2'h0);
    rdc(12'hc00, 32'h1, 2'h0);
  endtask : t_feature
  // entries, terminator, last slot, holes and refused places
  task automatic t_entries;
    rdc(12'h000, 32'h0000_1003, 2'h0);
    rdc(12'h004, 32'hffff_f037, 2'h0);
    rdc(12'h008, 32'h0, 2'h0);
    rdc(12'h7fc, 32'h0, 2'h0);
    chk(dap_u.comp_addr(32'h0, 32'hffff_f037), 32'hffff_f000);
    chk({31'h0, dap_u.is_final(32'h0000_1003, 511)}, 32'h1);
    chk({27'h0, dap_u.dom_of(32'h0000_1003, 5'h07)}, 32'h7);
    wrc(12'h004, 32'h0, 2'h0);
    rdc(12'h004, 32'hffff_f037, 2'h0);
    rdc(12'h900, 32'h0, 2'h2);
    rdc(12'hd00, 32'h0, 2'h2);
    rdc(12'h002, 32'h0, 2'h2);
    wrc(12'hd00, 32'h1, 2'h2);
  endtask : t_entries
  // power requests per domain, gated by the debug enable
  task automatic t_power;
    for (int i = 0; i < 5; i++)
      rdc(12'hb00 + 12'(4 * i), (i < 4) ? 32'h1 : 32'h0, 2'h0);
    wrc(12'hb00, 32'h2, 2'h0);
    rdc(12'hb00, 32'h3, 2'h0);
    chk(sys_pwr_req, 32'h1);
    wrc(12'hb10, 32'h2, 2'h0);
    rdc(12'hb10, 32'h0, 2'h0);
    wrc(12'hc40, 32'h0, 2'h0);
    rdc(12'hc40, 32'h0, 2'h0);
    wrc(12'hb04, 32'h2, 2'h0);
    rdc(12'hb04, 32'h1, 2'h0);
    wrc(12'hb00, 32'h1, 2'h0);
    chk(sys_pwr_req, 32'h0);
    wrc(12'hc40, 32'h1, 2'h0);
    wrc(12'hb0c, 32'h2, 2'h0);
    chk(sys_pwr_req, 32'h8);
  endtask : t_power
  // reset in mid-run drops the request and leaves the enable reading one
  task automatic t_reset;
    @(posedge clk);
    rst_b <= 1'b0;
    @(posedge clk);
    chk(sys_pwr_req, 32'h0);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk);
    rdc(12'hb0c, 32'h1, 2'h0);
    rdc(12'hc40, 32'h1, 2'h0);
  endtask : t_reset
  // ****
  // run control
  // ****
  task automatic final_report;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : final_report
  // main sequence after a four-cycle reset
  initial
  begin
    num_errors = 0;
    num_checks = 0;
    rst_b = 1'b0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    t_ident;
    t_feature;
    t_entries;
    t_power;
    t_reset;
    final_report;
  end
  // watchdog well beyond the 140 or so cycles the run needs
  initial
  begin
    repeat (20000) @(posedge clk);
    num_errors++;
    $display("BAD %0t: run did not finish", $time);
    final_report;
  end
endmodule : drt_regs_tb

/* verilog/drt_entry_rom.sv */
// constant component entry table: builds and sanitises each entry word
`timescale 1ns/1ns
module drt_entry_rom #(
  parameter int NUM_COMP = 2,
  parameter logic [19:0] COMP_OFS [0:1] = '{20'h00001, 20'hfffff},
  parameter logic [4:0] COMP_DOM [0:1] = '{5'h00, 5'h03},
  parameter logic [1:0] COMP_DOM_VALID = 2'h2
)(
  // index in
  input wire logic [8:0] idx,
  // entry out
  output logic [31:0] word
);
  // build one entry word, forcing the domain field to zero when no domain
  function automatic logic [31:0] make_entry(input logic [19:0] ofs, input logic [4:0] dom,
    input logic dv);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[31:12] = ofs; // R11 R12 R18
    w[8:4] = dv ? dom : 5'h00; // R14
    w[drt_pkg::DOM_VALID_BIT] = dv; // R15
    // a zero offset would point at the table itself: mark the slot skipped
    w[1:0] = (ofs == 20'h00000) ? drt_pkg::PRES_SKIP : drt_pkg::PRES_HERE; // R13
    return w;
  endfunction : make_entry

  // combinational lookup; slots past the last component read all zero
  always_comb
  begin
    word = drt_pkg::RESET_ZERO; // R9 R16
    for (int i = 0; i < NUM_COMP; i++)
    begin
      if (idx == 9'(i))
      begin
        word = make_entry(COMP_OFS[i], COMP_DOM[i], COMP_DOM_VALID[i]); // R7
      end
    end
    // final slot may only be final or present
    if (idx == 9'h1ff && word[1:0] == drt_pkg::PRES_SKIP)
    begin
      word = drt_pkg::RESET_ZERO; // R10
    end
  end
endmodule : drt_entry_rom

/* verilog/drt_pkg.sv */
// package of constants for the debug discovery table register bank
// How it works
// R1: peripheral ident 2 bit 3 reads one
// R2: peripheral ident 4 size field reads zero
// R3: feature id register upper bits read zero
// R4: bit 5 shows system reset request present
// R5: bit 4 shows debug reset request present
// R6: bits 3:0 give power request version code
// R7: at most 512 read-only entry words
// R8: entry n decoded at byte offset n*4
// R9: entry after last component terminates table
// R10: last slot code is final or present
// R11: entry offset field is signed 4KB block
// R12: offset selects block holding identification registers
// R13: present formatted entry never has zero offset
// R14: domain number only with valid flag, else zero
// R15: bit 2 flags meaningful domain number
// R16: presence codes: final, reserved, skipped, present
// R17: reader assumes table domain when none given
// R18: point only to external component views
// R19: one system power control register per domain
// R20: power writes ignored when debug fully disabled; here only writes raising a request are dropped
// R21: bit 1 requests power, bit 0 shows present
// R22: reserved bits zero, read-only writes ignored
package drt_pkg;
  // ****************************************
  // address map (byte offsets)
  // ****************************************
  localparam logic [11:0] ENTRY_BASE = 12'h000;
  localparam logic [11:0] ENTRY_LAST = 12'h7fc;
  localparam logic [11:0] SYS_PWR_CTRL_BASE = 12'hb00;
  localparam logic [11:0] SYS_PWR_CTRL_LAST = 12'hb7c;
  localparam logic [11:0] FEATURE_ID_OFS = 12'hc00;
  localparam logic [11:0] AUTH_CTRL_OFS = 12'hc40;
  localparam logic [11:0] PERIPH_ID4_OFS = 12'hfd0;
  localparam logic [11:0] PERIPH_ID5_OFS = 12'hfd4;
  localparam logic [11:0] PERIPH_ID6_OFS = 12'hfd8;
  localparam logic [11:0] PERIPH_ID7_OFS = 12'hfdc;
  localparam logic [11:0] PERIPH_ID0_OFS = 12'hfe0;
  localparam logic [11:0] PERIPH_ID1_OFS = 12'hfe4;
  localparam logic [11:0] PERIPH_ID2_OFS = 12'hfe8;
  localparam logic [11:0] PERIPH_ID3_OFS = 12'hfec;
  // ****************************************
  // field positions
  // ****************************************
  localparam int IDENT_SCHEME_BIT = 3;
  localparam int SYS_RR_BIT = 5;
  localparam int DBG_RR_BIT = 4;
  localparam int PWR_REQ_BIT = 1;
  localparam int PWR_PRESENT_BIT = 0;
  localparam int DOM_VALID_BIT = 2;
  // ****************************************
  // codes and counts
  // ****************************************
  localparam int MAX_ENTRIES = 512;
  localparam int MAX_DOMAINS = 32;
  localparam logic [3:0] SIZE_ONE_BLOCK = 4'h0;
  localparam logic [3:0] VERSION_NONE = 4'h0;
  localparam logic [3:0] VERSION_0 = 4'h1;
  localparam logic [1:0] PRES_FINAL = 2'h0;
  localparam logic [1:0] PRES_SKIP = 2'h2;
  localparam logic [1:0] PRES_HERE = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [31:0] RESET_ZERO = 32'h0000_0000;
endpackage : drt_pkg

/* verilog/drt_regs.sv */
// axi4-lite register bank of the debug discovery table
`timescale 1ns/1ns
module drt_regs #(
  parameter logic SYS_RR_PRESENT = 1'b0,
  parameter logic DBG_RR_PRESENT = 1'b0,
  parameter logic PWR_REQ_PRESENT = 1'b1,
  parameter logic [31:0] DOMAIN_PRESENT = 32'h0000_000f,
  parameter logic [7:0] PART_LO = 8'h5a, // arbitrary value
  parameter logic [3:0] PART_HI = 4'h1, // arbitrary value
  parameter logic [6:0] DESIGNER = 7'h2b, // arbitrary value
  parameter logic [3:0] DESIGNER_CONT = 4'h0, // arbitrary value
  parameter logic [3:0] REVISION = 4'h0,
  parameter logic [3:0] REV_AND = 4'h0,
  parameter logic [3:0] CUSTOMER_MODIFIED = 4'h0
)(
  // clock and reset
  input wire logic CLK,
  input wire logic RST_B,
  // write address channel
  input wire logic [11:0] AWADDR,
  input wire logic [2:0] AWPROT,
  input wire logic AWVALID,
  output logic AWREADY,
  // write data channel
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  // write response channel
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  // read address channel
  input wire logic [11:0] ARADDR,
  input wire logic [2:0] ARPROT,
  input wire logic ARVALID,
  output logic ARREADY,
  // read data channel
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  // system power requests, one per domain
  output logic [31:0] SYS_PWR_REQ
);
  // ****************************************
  // write channel
  // ****************************************
  logic aw_held; // address taken, waiting for data
  logic w_held; // data taken, waiting for address
  logic [11:0] aw_addr; // captured write address
  logic [31:0] w_data; // captured write data
  logic [3:0] w_strb; // captured strobes
  logic do_write; // both halves in hand this cycle
  logic debug_enabled; // cleared means all debug disabled
  logic [31:0] pwr_req; // per-domain request bits

  assign do_write = aw_held && w_held && !BVALID;

  // address capture; ready drops while a beat is held
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      aw_held <= 1'b0;
      aw_addr <= 12'h000;
      AWREADY <= 1'b0;
    end
    else
    begin
      AWREADY <= !aw_held && !(AWVALID && AWREADY) && !BVALID;
      if (AWVALID && AWREADY)
      begin
        aw_held <= 1'b1;
        aw_addr <= AWADDR;
      end
      else if (do_write)
      begin
        aw_held <= 1'b0;
      end
    end
  end

  // data capture, independent of address order
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      w_held <= 1'b0;
      w_data <= drt_pkg::RESET_ZERO;
      w_strb <= 4'h0;
      WREADY <= 1'b0;
    end
    else
    begin
      WREADY <= !w_held && !(WVALID && WREADY) && !BVALID;
      if (WVALID && WREADY)
      begin
        w_held <= 1'b1;
        w_data <= WDATA;
        w_strb <= WSTRB;
      end
      else if (do_write)
      begin
        w_held <= 1'b0;
      end
    end
  end

  // write decode: only the power control and auth words are writable
  function automatic logic is_pwr_ctrl(input logic [11:0] a);
    return a >= drt_pkg::SYS_PWR_CTRL_BASE && a <= drt_pkg::SYS_PWR_CTRL_LAST;
  endfunction : is_pwr_ctrl

  // response: all mapped or read-only addresses answer okay, holes slverr
  // the answer is decided from the held address, so a write to a hole
  // costs the same cycles as a real one and never touches any state
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      BVALID <= 1'b0;
      BRESP <= drt_pkg::RESP_OKAY;
    end
    else if (do_write)
    begin
      BVALID <= 1'b1;
      BRESP <= is_mapped(aw_addr) ? drt_pkg::RESP_OKAY : drt_pkg::RESP_SLVERR;
    end
    else if (BREADY)
    begin
      BVALID <= 1'b0;
    end
  end

  // debug enable control word, bit 0, reset enabled
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      debug_enabled <= 1'b1;
    end
    else if (do_write && aw_addr == drt_pkg::AUTH_CTRL_OFS && w_strb[0])
    begin
      debug_enabled <= w_data[0];
    end
  end

  // per-domain power request bits via generate
  genvar g;
  generate
    for (g = 0; g < drt_pkg::MAX_DOMAINS; g++)
    begin : g_dom
      always_ff @(posedge CLK or negedge RST_B)
      begin
        if (!RST_B)
        begin
          pwr_req[g] <= 1'b0;
        end
        else if (!DOMAIN_PRESENT[g] || !PWR_REQ_PRESENT)
        begin
          pwr_req[g] <= 1'b0; // unimplemented domain stays clear
        end
        else if (do_write && is_pwr_ctrl(aw_addr) && aw_addr[6:2] == 5'(g) && w_strb[0])
        begin
          // a request to raise power is dropped when debug is off
          if (debug_enabled || !w_data[drt_pkg::PWR_REQ_BIT]) // R20
          begin
            pwr_req[g] <= w_data[drt_pkg::PWR_REQ_BIT]; // R19 R21
          end
        end
      end
    end
  endgenerate

  // request outputs registered by construction
  assign SYS_PWR_REQ = pwr_req;

  // ****************************************
  // read channel
  // ****************************************
  logic [31:0] entry_word; // table lookup result
  logic [31:0] next_rdata; // decoded read value
  logic next_rerr; // unmapped read

  // address range check used by both channels
  function automatic logic is_mapped(input logic [11:0] a);
    return a <= drt_pkg::ENTRY_LAST || is_pwr_ctrl(a) || a == drt_pkg::FEATURE_ID_OFS
      || a == drt_pkg::AUTH_CTRL_OFS
      || (a >= drt_pkg::PERIPH_ID4_OFS && a <= drt_pkg::PERIPH_ID3_OFS);
  endfunction : is_mapped

  drt_entry_rom u_rom (
    .idx(ARADDR[10:2]), // R8
    .word(entry_word)
  );

  // read decode; every unlisted bit reads zero
  always_comb
  begin
    next_rdata = drt_pkg::RESET_ZERO; // R22
    next_rerr = 1'b0;
    if (ARADDR[1:0] != 2'h0)
    begin
      next_rerr = 1'b1;
    end
    else if (ARADDR <= drt_pkg::ENTRY_LAST)
    begin
      next_rdata = entry_word; // R7 R8
    end
    else if (is_pwr_ctrl(ARADDR))
    begin
      next_rdata[drt_pkg::PWR_PRESENT_BIT] = PWR_REQ_PRESENT && DOMAIN_PRESENT[ARADDR[6:2]]; // R21
      next_rdata[drt_pkg::PWR_REQ_BIT] = pwr_req[ARADDR[6:2]];
    end
    else if (ARADDR == drt_pkg::FEATURE_ID_OFS)
    begin
      next_rdata[drt_pkg::SYS_RR_BIT] = SYS_RR_PRESENT; // R4
      next_rdata[drt_pkg::DBG_RR_BIT] = DBG_RR_PRESENT; // R5
      next_rdata[3:0] = PWR_REQ_PRESENT ? drt_pkg::VERSION_0 : drt_pkg::VERSION_NONE; // R6 R3
    end
    else if (ARADDR == drt_pkg::AUTH_CTRL_OFS)
    begin
      next_rdata[0] = debug_enabled;
    end
    else if (ARADDR == drt_pkg::PERIPH_ID0_OFS)
    begin
      next_rdata[7:0] = PART_LO;
    end
    else if (ARADDR == drt_pkg::PERIPH_ID1_OFS)
    begin
      next_rdata[7:0] = {DESIGNER[3:0], PART_HI};
    end
    else if (ARADDR == drt_pkg::PERIPH_ID2_OFS)
    begin
      next_rdata[7:0] = {REVISION, 1'b1, DESIGNER[6:4]}; // R1
    end
    else if (ARADDR == drt_pkg::PERIPH_ID3_OFS)
    begin
      next_rdata[7:0] = {REV_AND, CUSTOMER_MODIFIED};
    end
    else if (ARADDR == drt_pkg::PERIPH_ID4_OFS)
    begin
      next_rdata[7:0] = {drt_pkg::SIZE_ONE_BLOCK, DESIGNER_CONT}; // R2
    end
    else if (!is_mapped(ARADDR))
    begin
      next_rerr = 1'b1;
    end
  end

  // one read in flight; answer the cycle after the address is taken
  // the word is latched from the decode at the address handshake, while the
  // master still holds ARADDR; holding the answer in flops costs a cycle
  // but keeps RDATA free of decode glitches
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      ARREADY <= 1'b0;
      RVALID <= 1'b0;
      RDATA <= drt_pkg::RESET_ZERO;
      RRESP <= drt_pkg::RESP_OKAY;
    end
    else
    begin
      ARREADY <= !RVALID && !(ARVALID && ARREADY);
      if (ARVALID && ARREADY)
      begin
        RVALID <= 1'b1;
        RDATA <= next_rdata;
        RRESP <= next_rerr ? drt_pkg::RESP_SLVERR : drt_pkg::RESP_OKAY;
      end
      else if (RREADY)
      begin
        RVALID <= 1'b0;
      end
    end
  end

  // ****************************************
  // checks
  // ****************************************
  a_feature_upper: assert property (@(posedge CLK) disable iff (!RST_B) // R3
    (ARVALID && ARREADY && ARADDR == drt_pkg::FEATURE_ID_OFS) |=> RDATA[31:6] == 26'h0)
    else $error("feature id upper bits not zero");
  a_ident_scheme: assert property (@(posedge CLK) disable iff (!RST_B) // R1
    (ARVALID && ARREADY && ARADDR == drt_pkg::PERIPH_ID2_OFS) |=> RDATA[3])
    else $error("ident scheme bit not set");
  a_size_zero: assert property (@(posedge CLK) disable iff (!RST_B) // R2
    (ARVALID && ARREADY && ARADDR == drt_pkg::PERIPH_ID4_OFS) |=> RDATA[7:4] == 4'h0)
    else $error("size field not zero");
  a_feature_version: assert property (@(posedge CLK) disable iff (!RST_B) // R6
    (ARVALID && ARREADY && ARADDR == drt_pkg::FEATURE_ID_OFS) |=>
    RDATA[3:0] == (PWR_REQ_PRESENT ? 4'h1 : 4'h0) && RDATA[5] == SYS_RR_PRESENT)
    else $error("feature id fields wrong");
  a_final_clean: assert property (@(posedge CLK) disable iff (!RST_B) // R16
    (ARVALID && ARREADY && ARADDR <= drt_pkg::ENTRY_LAST) |=>
    (RDATA[1:0] != 2'h0 || RDATA == 32'h0))
    else $error("final entry not all zero");
  a_domain_gate: assert property (@(posedge CLK) disable iff (!RST_B) // R14
    (ARVALID && ARREADY && ARADDR <= drt_pkg::ENTRY_LAST) |=> (RDATA[2] || RDATA[8:4] == 5'h0))
    else $error("domain number without valid flag");
  a_no_self_ptr: assert property (@(posedge CLK) disable iff (!RST_B) // R13
    (ARVALID && ARREADY && ARADDR <= drt_pkg::ENTRY_LAST) |=>
    !(RDATA[1:0] == 2'h3 && RDATA[31:12] == 20'h0))
    else $error("present entry points at table");
  a_pwr_locked: assert property (@(posedge CLK) disable iff (!RST_B) // R20
    !debug_enabled |=> (SYS_PWR_REQ & ~$past(SYS_PWR_REQ)) == 32'h0)
    else $error("power request raised while debug disabled");
  a_ro_write: assert property (@(posedge CLK) disable iff (!RST_B) // R22
    (do_write && aw_addr == drt_pkg::FEATURE_ID_OFS) |=> $stable(pwr_req) && $stable(debug_enabled))
    else $error("read-only write had side effect");
  // ****************************************
  // table, identification, feature and power word checks
  // ****************************************
  // the last slot never shows a skipped or reserved code
  a_last_slot: assert property (@(posedge CLK) disable iff (!RST_B) // R10
    (ARVALID && ARREADY && ARADDR == drt_pkg::ENTRY_LAST) |=> RDATA[1:0] inside {2'h0, 2'h3})
    else $error("last slot holds a skipped or reserved code");
  // reserved entry bits stay clear
  a_entry_res0: assert property (@(posedge CLK) disable iff (!RST_B) // R22
    (ARVALID && ARREADY && ARADDR <= drt_pkg::ENTRY_LAST) |=> RDATA[11:9] == 3'h0 && !RDATA[3])
    else $error("reserved entry bits set");
  // identification words use the low byte only
  a_ident_upper: assert property (@(posedge CLK) disable iff (!RST_B) // R22
    (ARVALID && ARREADY && ARADDR >= drt_pkg::PERIPH_ID4_OFS
    && ARADDR <= drt_pkg::PERIPH_ID3_OFS) |=> RDATA[31:8] == 24'h0)
    else $error("identification upper bits not zero");
  // debug reset capability flag follows its parameter
  a_feature_dbg: assert property (@(posedge CLK) disable iff (!RST_B) // R5
    (ARVALID && ARREADY && ARADDR == drt_pkg::FEATURE_ID_OFS) |=> RDATA[4] == DBG_RR_PRESENT)
    else $error("debug reset flag wrong");
  // control words show presence in bit 0 and nothing above bit 1
  a_pwr_present: assert property (@(posedge CLK) disable iff (!RST_B) // R21
    (ARVALID && ARREADY && is_pwr_ctrl(ARADDR) && ARADDR[1:0] == 2'h0) |=> RDATA[31:2] == 30'h0
    && RDATA[0] == (PWR_REQ_PRESENT && DOMAIN_PRESENT[$past(ARADDR[6:2])]))
    else $error("power control read wrong");
  // a domain without a request mechanism is never powered from here
  a_dom_unimpl: assert property (@(posedge CLK) disable iff (!RST_B) // R19
    (SYS_PWR_REQ & ~DOMAIN_PRESENT) == 32'h0)
    else $error("request raised for a missing domain");
  // a write to a read-only word still answers okay
  a_ro_okay: assert property (@(posedge CLK) disable iff (!RST_B) // R22
    (do_write && aw_addr == drt_pkg::FEATURE_ID_OFS) |=> BVALID && BRESP == drt_pkg::RESP_OKAY)
    else $error("read-only write refused");
  // an allowed write to domain 0 shows at its request output next cycle
  a_pwr_taken: assert property (@(posedge CLK) disable iff (!RST_B) // R19
    (do_write && aw_addr == drt_pkg::SYS_PWR_CTRL_BASE && w_strb[0] && debug_enabled
    && PWR_REQ_PRESENT && DOMAIN_PRESENT[0])
    |=> SYS_PWR_REQ[0] == $past(w_data[drt_pkg::PWR_REQ_BIT]))
    else $error("power request write not applied");
endmodule : drt_regs
